/* File: logic/fbm_defines.svh */
// register offsets, field positions, reset values and timing counts of the exchange control
`ifndef FBM_DEFINES_SVH
`define FBM_DEFINES_SVH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define FBM_A_MAPMODE   8'h00
`define FBM_A_MAPSTART  8'h04
`define FBM_A_XMODE     8'h08
`define FBM_A_FAULT     8'h0C
`define FBM_A_CTRL      8'h10
`define FBM_A_INIT      8'h14
`define FBM_A_REFRESH   8'h18
`define FBM_A_MBXWR     8'h1C
`define FBM_A_MBXRD     8'h20
`define FBM_A_STAT      8'h24
`define FBM_A_MAPOUT    8'h28
// ---------------------------------------------------------------
// control word fields and command bits
// ---------------------------------------------------------------
`define FBM_CTRL_RUN    0
`define FBM_CTRL_INH    1
`define FBM_CTRL_MCLR   2
`define FBM_CTRL_ISSUE  7
`define FBM_CMD_LO      9
`define FBM_CMD_HI      13
`define FBM_CMD_UNFRZ   1
`define FBM_CMD_FRZ     2
`define FBM_CMD_UNSYNC  3
`define FBM_CMD_SYNC    4
`define FBM_CTRL_RST    16'h0000
// ---------------------------------------------------------------
// settings codes and accepted start ranges
// ---------------------------------------------------------------
`define FBM_MAP_USER      16'h0001
`define FBM_XMODE_ASYNC   16'h0000
`define FBM_FAULT_CLEAR   16'h0000
`define FBM_SET_RST       16'h0000
`define FBM_MAP_DEF_START 16'h0200
`define FBM_STATUS_WORDS  5'd16
`define FBM_GEN_MAX       16'h5984
`define FBM_RELAY_LO_MAX  12'h220
`define FBM_RELAY_HI_MIN  12'h300
`define FBM_RELAY_HI_MAX  12'h496
`define FBM_HOLD_MAX      12'h084
`define FBM_LINK_MAX      12'h048
// ---------------------------------------------------------------
// status word bits
// ---------------------------------------------------------------
`define FBM_ST_OMB_FULL 0
`define FBM_ST_IMB_AVL  1
`define FBM_ST_IMB_FULL 2
`define FBM_ST_REFUSED  4
`define FBM_ST_SYNC     5
`define FBM_ST_HOLD     6
`define FBM_ST_BUSY     7
`define FBM_ST_ACCEPT   11
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define FBM_CLK_NS       4
`define FBM_FB_CYCLE_NS  2000
`define FBM_FB_CYCLE_CYC ((`FBM_FB_CYCLE_NS) / (`FBM_CLK_NS))
`endif

/* File: logic/fbm_pkg.sv */
// types shared by the exchange control files
package fbm_pkg;
   typedef enum logic [1:0] {
      FBM_NET_OPERATE = 2'b00,
      FBM_NET_CLEAR   = 2'b01,
      FBM_NET_STOP    = 2'b11
   } fbm_net_e;
   typedef enum logic [1:0] {
      FBM_AREA_RELAY = 2'b00,
      FBM_AREA_HOLD  = 2'b01,
      FBM_AREA_LINK  = 2'b10,
      FBM_AREA_GEN   = 2'b11
   } fbm_area_e;
   typedef struct packed {
      logic        ctrl;
      logic [15:0] word;
   } fbm_mbx_s;
   typedef struct packed {
      logic        user;
      fbm_area_e   area;
      logic [15:0] start;
   } fbm_map_s;
endpackage

/* File: logic/fbm_exchange_ctrl.sv */
// fieldbus master exchange control: settings decode, cycle trigger, fault reaction, mailboxes
`timescale 1ns/1ns
`include "fbm_defines.svh"

// ---------------------------------------------------------------
// mailbox storage
// ---------------------------------------------------------------
module fbm_mbx_fifo import fbm_pkg::*; #(
   parameter int DEPTH = 4,
   parameter int AW    = $clog2(DEPTH)
) (
   input  wire logic     pclk,
   input  wire logic     presetn,
   input  wire logic     push,
   input  wire fbm_mbx_s din,
   input  wire logic     pop,
   output fbm_mbx_s      dout,
   output logic          full,
   output logic          empty
);
   fbm_mbx_s      mem_q [DEPTH];
   logic [AW-1:0] wp_q;
   logic [AW-1:0] rp_q;
   logic [AW:0]   cnt_q;
   logic          do_push;
   logic          do_pop;

   // pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("mailbox depth must be a power of two of at least 2");
   end

   assign full    = (cnt_q == (AW+1)'(DEPTH));
   assign empty   = (cnt_q == '0);
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign dout    = mem_q[rp_q];

   // entry data carries no reset, only the pointers say what is valid
   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem_q[wp_q] <= din;
      end
   end

   // pointers and fill count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (do_push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
   end
endmodule

// ---------------------------------------------------------------
// exchange control top
// ---------------------------------------------------------------
module fbm_exchange_ctrl import fbm_pkg::*; #(
   parameter int OMB_DEPTH    = 4,
   parameter int IMB_DEPTH    = 4,
   parameter int FB_CYCLE_CYC = `FBM_FB_CYCLE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             fb_cycle_start,
   output logic             fb_out_send,
   output logic             fb_out_zero,
   output fbm_net_e         fb_net_state,
   output logic             fb_cmd_valid,
   output logic [15:0]      fb_cmd_word,
   input  wire logic        fb_rsp_valid,
   input  wire logic [15:0] fb_rsp_word,
   output logic             io_exchange
);
   if (FB_CYCLE_CYC < 2 || FB_CYCLE_CYC > 65535) begin : g_chk
      $error("fieldbus cycle count out of range");
   end

   logic [31:0] prdata_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] rd_d;
   logic        err_d;
   logic [15:0] map_mode_q;
   logic [15:0] map_start_q;
   logic [15:0] xmode_q;
   logic [15:0] fault_q;
   logic [15:0] ctrl_q;
   fbm_map_s    map_q;
   logic        sync_q;
   logic        hold_q;
   logic        run_prev_q;
   fbm_net_e    net_q;
   logic        zero_q;
   logic        send_q;
   logic [15:0] cyc_cnt_q;
   logic        cyc_start_q;
   logic        busy_q;
   logic        busy_ctrl_q;
   logic        cmd_valid_q;
   logic [15:0] cmd_word_q;
   logic        accept_q;
   logic        refused_q;
   logic        xchg_q;
   logic        done;
   logic        wr_done;
   logic        init_ev;
   logic        refresh_ev;
   logic        mbxwr_ev;
   logic        run;
   logic        inh;
   logic        run_fall;
   logic        run_rise;
   logic        issue_ok;
   logic        wr_ok;
   logic        dispatch;
   logic [4:0]  cmd_bits;
   fbm_mbx_s    omb_din;
   fbm_mbx_s    omb_head;
   fbm_mbx_s    imb_head;
   logic        omb_full;
   logic        omb_empty;
   logic        imb_full;
   logic        imb_empty;
   logic        omb_push;
   logic        imb_push;
   logic        imb_pop;

   // ---------------------------------------------------------------
   // bus slave: one wait state, write and pop at the completing edge
   // ---------------------------------------------------------------
   assign done       = psel & penable & pready_q;
   assign wr_done    = done & pwrite;
   assign init_ev    = wr_done && paddr == `FBM_A_INIT;
   assign refresh_ev = wr_done && paddr == `FBM_A_REFRESH;
   assign mbxwr_ev   = wr_done && paddr == `FBM_A_MBXWR;
   assign run        = ctrl_q[`FBM_CTRL_RUN];
   assign inh        = ctrl_q[`FBM_CTRL_INH];
   assign run_fall   = run_prev_q & ~run;
   assign run_rise   = ~run_prev_q & run;

   // read view of the registers
   always_comb begin
      rd_d  = '0;
      err_d = 1'b0;
      case (paddr)
         `FBM_A_MAPMODE:  rd_d = {16'h0000, map_mode_q};
         `FBM_A_MAPSTART: rd_d = {16'h0000, map_start_q};
         `FBM_A_XMODE:    rd_d = {16'h0000, xmode_q};
         `FBM_A_FAULT:    rd_d = {16'h0000, fault_q};
         `FBM_A_CTRL:     rd_d = {16'h0000, ctrl_q};
         `FBM_A_MBXRD:    rd_d = {15'h0000, ~imb_empty, imb_head.word};
         `FBM_A_STAT: begin
            rd_d[`FBM_ST_OMB_FULL] = omb_full;
            rd_d[`FBM_ST_IMB_AVL]  = ~imb_empty;
            rd_d[`FBM_ST_IMB_FULL] = imb_full;
            rd_d[`FBM_ST_REFUSED]  = refused_q;
            rd_d[`FBM_ST_SYNC]     = sync_q;
            rd_d[`FBM_ST_HOLD]     = hold_q;
            rd_d[`FBM_ST_BUSY]     = busy_q;
            rd_d[9:8]              = net_q;
            rd_d[`FBM_ST_ACCEPT]   = accept_q;
         end
         `FBM_A_MAPOUT:   rd_d = {8'h00, `FBM_STATUS_WORDS, map_q};
         `FBM_A_INIT, `FBM_A_REFRESH, `FBM_A_MBXWR: rd_d = '0;
         default:         err_d = 1'b1;
      endcase
   end

   // answer registers; data is caught one edge before completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         prdata_q  <= '0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel && penable && !pready_q) begin
            prdata_q  <= pwrite ? '0 : rd_d;
            pslverr_q <= err_d;
         end
      end
   end

   // settings words and control word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_mode_q  <= `FBM_SET_RST;
         map_start_q <= `FBM_SET_RST;
         xmode_q     <= `FBM_SET_RST;
         fault_q     <= `FBM_SET_RST;
         ctrl_q      <= `FBM_CTRL_RST;
      end else if (wr_done && !pslverr_q) begin
         case (paddr)
            `FBM_A_MAPMODE:  map_mode_q  <= pwdata[15:0];
            `FBM_A_MAPSTART: map_start_q <= pwdata[15:0];
            `FBM_A_XMODE:    xmode_q     <= pwdata[15:0];
            `FBM_A_FAULT:    fault_q     <= pwdata[15:0];
            `FBM_A_CTRL:     ctrl_q      <= pwdata[15:0];
            default:         ctrl_q      <= ctrl_q;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // settings decode, latched only at initialisation
   // ---------------------------------------------------------------
   function automatic fbm_map_s map_decode(input logic [15:0] mode, input logic [15:0] st);
      fbm_map_s    m;
      fbm_area_e   area;
      logic [11:0] n;
      logic        ok;
      n    = st[11:0];
      m    = '{1'b0, FBM_AREA_RELAY, `FBM_MAP_DEF_START};
      ok   = (st[11:8] <= 4'h9) && (st[7:4] <= 4'h9) && (st[3:0] <= 4'h9);
      area = FBM_AREA_GEN;
      case (st[15:12])
         4'hA: begin
            area = FBM_AREA_RELAY;
            ok   = ok && (n <= `FBM_RELAY_LO_MAX
                   || (n >= `FBM_RELAY_HI_MIN && n <= `FBM_RELAY_HI_MAX));
         end
         4'hB: begin
            area = FBM_AREA_HOLD;
            ok   = ok && (n <= `FBM_HOLD_MAX);
         end
         4'hC: begin
            area = FBM_AREA_LINK;
            ok   = ok && (n <= `FBM_LINK_MAX);
         end
         default: ok = ok && (st <= `FBM_GEN_MAX);
      endcase
      // anything unaccepted keeps the fixed default block
      if (mode == `FBM_MAP_USER && ok) begin
         m = '{1'b1, area, (area == FBM_AREA_GEN) ? st : {4'h0, n}};
      end
      return m;
   endfunction

   // a later change of the words has no effect until the next init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_q  <= '{1'b0, FBM_AREA_RELAY, `FBM_MAP_DEF_START};
         sync_q <= 1'b0;
         hold_q <= 1'b0;
      end else if (init_ev) begin
         map_q  <= map_decode(map_mode_q, map_start_q);
         sync_q <= (xmode_q != `FBM_XMODE_ASYNC);
         hold_q <= (fault_q != `FBM_FAULT_CLEAR);
      end
   end

   // ---------------------------------------------------------------
   // fieldbus cycle trigger
   // ---------------------------------------------------------------
   // the own timer keeps running when the host stops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_cnt_q   <= '0;
         cyc_start_q <= 1'b0;
      end else if (sync_q) begin
         cyc_cnt_q   <= '0;
         cyc_start_q <= refresh_ev & run & ~inh;
      end else if (inh) begin
         cyc_cnt_q   <= '0;
         cyc_start_q <= 1'b0;
      end else begin
         cyc_start_q <= (cyc_cnt_q == 16'(FB_CYCLE_CYC - 1));
         cyc_cnt_q   <= (cyc_cnt_q == 16'(FB_CYCLE_CYC - 1)) ? '0 : cyc_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // run bit reaction and network state
   // ---------------------------------------------------------------
   // a fault and a deliberate clear look alike here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_prev_q <= 1'b0;
         zero_q     <= 1'b0;
         send_q     <= 1'b0;
         xchg_q     <= 1'b0;
      end else begin
         run_prev_q <= run;
         xchg_q     <= run & ~inh;
         if (run_fall) begin
            zero_q <= sync_q | ~hold_q;
            send_q <= ~sync_q & ~hold_q & ~inh;
         end else if (run_rise) begin
            zero_q <= 1'b0;
            send_q <= ~inh;
         end else if (run) begin
            send_q <= ~inh;
         end
      end
   end

   // synchronous mode cannot keep outputs, so it walks down to stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         net_q <= FBM_NET_OPERATE;
      end else begin
         case (net_q)
            FBM_NET_OPERATE: begin
               if ((run_fall && sync_q) || (run && inh)) begin
                  net_q <= FBM_NET_CLEAR;
               end
            end
            FBM_NET_CLEAR: net_q <= FBM_NET_STOP;
            FBM_NET_STOP: begin
               if (run && !inh) begin
                  net_q <= FBM_NET_OPERATE;
               end
            end
            default: net_q <= FBM_NET_OPERATE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // mailboxes
   // ---------------------------------------------------------------
   // unsync beats sync and unfreeze beats freeze
   always_comb begin
      cmd_bits = ctrl_q[`FBM_CMD_HI:`FBM_CMD_LO];
      if (cmd_bits[`FBM_CMD_UNSYNC]) begin
         cmd_bits[`FBM_CMD_SYNC] = 1'b0;
      end
      if (cmd_bits[`FBM_CMD_UNFRZ]) begin
         cmd_bits[`FBM_CMD_FRZ] = 1'b0;
      end
   end

   // both sources are bus writes, so they never meet in one cycle
   assign issue_ok = refresh_ev & ctrl_q[`FBM_CTRL_ISSUE] & run & ~inh
                     & ~omb_full & ~imb_full;
   assign wr_ok    = mbxwr_ev & run & ~inh & ~omb_full & ~imb_full;
   assign omb_push = issue_ok | wr_ok;
   assign omb_din  = issue_ok ? fbm_mbx_s'{1'b1, {11'h000, cmd_bits}}
                              : fbm_mbx_s'{1'b0, pwdata[15:0]};
   // one command on the wire at a time keeps a free slot for its answer
   assign dispatch = ~busy_q & ~omb_empty & ~imb_full & run & ~inh;
   assign imb_push = fb_rsp_valid & busy_q & ~busy_ctrl_q;
   assign imb_pop  = (refresh_ev & ctrl_q[`FBM_CTRL_MCLR])
                     | (done && !pwrite && paddr == `FBM_A_MBXRD && prdata_q[16]);

   fbm_mbx_fifo #(
      .DEPTH (OMB_DEPTH)
   ) u_omb (
      .pclk    (pclk),
      .presetn (presetn),
      .push    (omb_push),
      .din     (omb_din),
      .pop     (dispatch),
      .dout    (omb_head),
      .full    (omb_full),
      .empty   (omb_empty)
   );

   fbm_mbx_fifo #(
      .DEPTH (IMB_DEPTH)
   ) u_imb (
      .pclk    (pclk),
      .presetn (presetn),
      .push    (imb_push),
      .din     (fbm_mbx_s'{1'b0, fb_rsp_word}),
      .pop     (imb_pop),
      .dout    (imb_head),
      .full    (imb_full),
      .empty   (imb_empty)
   );

   // command hand-off to the fieldbus engine and status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q      <= 1'b0;
         busy_ctrl_q <= 1'b0;
         cmd_valid_q <= 1'b0;
         cmd_word_q  <= '0;
         accept_q    <= 1'b0;
         refused_q   <= 1'b0;
      end else begin
         cmd_valid_q <= dispatch;
         if (dispatch) begin
            busy_q      <= 1'b1;
            busy_ctrl_q <= omb_head.ctrl;
            cmd_word_q  <= omb_head.word;
         end else if (fb_rsp_valid) begin
            busy_q <= 1'b0;
         end
         if (refresh_ev && ctrl_q[`FBM_CTRL_ISSUE]) begin
            accept_q <= issue_ok;
         end
         if (mbxwr_ev) begin
            refused_q <= ~wr_ok;
         end
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = pslverr_q;
   assign fb_cycle_start = cyc_start_q;
   assign fb_out_send    = send_q;
   assign fb_out_zero    = zero_q;
   assign fb_net_state   = net_q;
   assign fb_cmd_valid   = cmd_valid_q;
   assign fb_cmd_word    = cmd_word_q;
   assign io_exchange    = xchg_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_walk_down;
      net_q == FBM_NET_CLEAR ##1 net_q == FBM_NET_STOP;
   endsequence

   a_sync_one_cycle: assert property (sync_q && refresh_ev && run && !inh |=> cyc_start_q)
      else $error("no cycle after refresh");
   a_sync_no_extra: assert property (sync_q && !refresh_ev |=> !cyc_start_q)
      else $error("extra synchronous cycle");
   a_async_timer: assert property (!sync_q && !inh && cyc_start_q
      |-> $past(cyc_cnt_q) == 16'(FB_CYCLE_CYC - 1)) else $error("async cycle off its timer");
   a_clear_react: assert property (run_fall && !sync_q && !hold_q |=> zero_q
      && send_q == !$past(inh)) else $error("clear reaction wrong");
   a_hold_react: assert property (run_fall && !sync_q && hold_q |=> !send_q && !zero_q)
      else $error("hold reaction wrong");
   a_sync_stop: assert property (run_fall && sync_q && net_q == FBM_NET_OPERATE
      |=> s_walk_down) else $error("network did not walk to stop");
   a_sync_zero: assert property (run_fall && sync_q |=> zero_q && !send_q)
      else $error("sync stop kept outputs");
   a_refuse_full: assert property (imb_full |-> !omb_push && !dispatch)
      else $error("command taken while input mailbox full");
   a_ctrl_drop: assert property (busy_q && busy_ctrl_q && fb_rsp_valid |-> !imb_push)
      else $error("control response kept");
   a_run_idle: assert property (!run |-> !omb_push && !dispatch ##1 !cmd_valid_q)
      else $error("mailbox active with run clear");
   a_map_default: assert property (init_ev && map_mode_q != `FBM_MAP_USER
      |=> map_q.start == `FBM_MAP_DEF_START && !map_q.user) else $error("default map lost");
   a_apb_answer: assert property (psel && penable && !pready_q |=> pready_q)
      else $error("bus answer late");
endmodule

/* File: sim/fbm_engine_model.sv */
// fieldbus engine model answering dispatched commands
`timescale 1ns/1ns
module fbm_engine_model (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        fb_cmd_valid,
   input  wire logic [15:0] fb_cmd_word,
   output logic             fb_rsp_valid,
   output logic [15:0]      fb_rsp_word
);
   logic [2:0] dly_q;
   // one answer per command, late; word churns when idle so no stale value lingers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dly_q <= 3'h0;
         fb_rsp_valid <= 1'b0;
         fb_rsp_word <= 16'h0000;
      end else begin
         fb_rsp_valid <= dly_q == 3'h1;
         fb_rsp_word <= (dly_q == 3'h1) ? ~fb_cmd_word : ~fb_rsp_word;
         if (fb_cmd_valid) dly_q <= 3'h3;
         else if (dly_q != 3'h0) dly_q <= dly_q - 3'h1;
      end
   end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the exchange control
`timescale 1ns/1ns
`include "fbm_defines.svh"
module testbench import fbm_pkg::*;;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        fcs, send, zero, cv, rv, er, xchg;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] cw, rw;
   fbm_net_e    net;
   int          miscompares, checks, pulses, ticks;
   fbm_exchange_ctrl #(.FB_CYCLE_CYC(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fb_cycle_start(fcs), .fb_out_send(send),
      .fb_out_zero(zero), .fb_net_state(net), .fb_cmd_valid(cv), .fb_cmd_word(cw),
      .fb_rsp_valid(rv), .fb_rsp_word(rw), .io_exchange(xchg));
   fbm_engine_model eng (.pclk(pclk), .presetn(presetn), .fb_cmd_valid(cv),
      .fb_cmd_word(cw), .fb_rsp_valid(rv), .fb_rsp_word(rw));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // bounds the run and counts cycle triggers
   always @(posedge pclk) begin
      ticks++;
      if (fcs === 1'b1) pulses++;
      if (ticks == 20000) begin
         miscompares++;
         close_out;
      end
   end
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one transfer; idle cycle after it so psel is never driven twice in a step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready ends this wait; only the bench timeout ends one that never sees it
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d});
   endtask
   task automatic t_map;
      logic [15:0] st [9] = '{16'h0000, 16'h5984, 16'h5985, 16'hA220, 16'hC049, 16'hB084,
                              16'hA496, 16'hA230, 16'hC048};
      logic [31:0] ex [9] = '{32'h0080_0200, 32'h0087_5984, 32'h0080_0200,
                              32'h0084_0220, 32'h0080_0200, 32'h0085_0084,
                              32'h0084_0496, 32'h0080_0200, 32'h0086_0048};
      for (int i = 0; i < 9; i++) begin
         wr(`FBM_A_MAPMODE, (i == 0) ? 16'h0000 : 16'h0001);
         wr(`FBM_A_MAPSTART, st[i]);
         wr(`FBM_A_INIT, 16'h0000);
         apb(1'b0, `FBM_A_MAPOUT, 32'h0);
         chk("map", rd, ex[i]);
      end
      wr(`FBM_A_MAPMODE, 16'h0000);
      apb(1'b0, `FBM_A_MAPOUT, 32'h0);
      chk("map held", rd, 32'h0086_0048);
      apb(1'b0, 8'hFC, 32'h0);
      chk("pslverr", {31'h0, er}, 32'h1);
   endtask
   task automatic t_mbx;
      wr(`FBM_A_CTRL, 16'h0001);
      wr(`FBM_A_MBXWR, 16'h1234);
      repeat (12) @(posedge pclk);
      apb(1'b0, `FBM_A_MBXRD, 32'h0);
      chk("mbx", rd, 32'h0001_EDCB);
      wr(`FBM_A_CTRL, 16'h0281);
      wr(`FBM_A_REFRESH, 16'h0000);
      repeat (12) @(posedge pclk);
      apb(1'b0, `FBM_A_STAT, 32'h0);
      chk("accepted", {31'h0, rd[11]}, 32'h1);
      chk("cmd word", {16'h0000, cw}, 32'h0000_0001);
      wr(`FBM_A_CTRL, 16'h3C81);
      wr(`FBM_A_REFRESH, 16'h0000);
      repeat (12) @(posedge pclk);
      chk("cmd prio", {16'h0000, cw}, 32'h0000_000A);
      apb(1'b0, `FBM_A_MBXRD, 32'h0);
      chk("mbx empty", {31'h0, rd[16]}, 32'h0);
   endtask
   task automatic t_fault;
      wr(`FBM_A_CTRL, 16'h0000);
      repeat (3) @(posedge pclk);
      chk("zero", {31'h0, zero}, 32'h1);
      chk("send", {31'h0, send}, 32'h1);
      pulses = 0;
      repeat (40) @(posedge pclk);
      chk("async", {31'h0, pulses >= 4}, 32'h1);
      wr(`FBM_A_FAULT, 16'h0001);
      wr(`FBM_A_INIT, 16'h0000);
      wr(`FBM_A_CTRL, 16'h0001);
      wr(`FBM_A_CTRL, 16'h0000);
      repeat (3) @(posedge pclk);
      chk("hold", {30'h0, zero, send}, 32'h0);
   endtask
   task automatic t_sync;
      wr(`FBM_A_XMODE, 16'h0001);
      wr(`FBM_A_INIT, 16'h0000);
      wr(`FBM_A_CTRL, 16'h0001);
      pulses = 0;
      wr(`FBM_A_REFRESH, 16'h0000);
      repeat (20) @(posedge pclk);
      chk("sync", pulses, 32'h1);
      wr(`FBM_A_CTRL, 16'h0000);
      repeat (6) @(posedge pclk);
      chk("net", {30'h0, net}, {30'h0, FBM_NET_STOP});
      chk("zero", {31'h0, zero}, 32'h1);
   endtask
   // four answers fill the input mailbox while a fifth command waits behind them
   task automatic t_full;
      wr(`FBM_A_CTRL, 16'h0001);
      for (int i = 0; i < 5; i++) begin
         wr(`FBM_A_MBXWR, 16'h0010 + 16'(i));
      end
      repeat (40) @(posedge pclk);
      apb(1'b0, `FBM_A_STAT, 32'h0);
      chk("mbx full", {28'h0, rd[4], rd[2:0]}, 32'h6);
      wr(`FBM_A_MBXWR, 16'h0099);
      apb(1'b0, `FBM_A_STAT, 32'h0);
      chk("mbx refused", {31'h0, rd[4]}, 32'h1);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, `FBM_A_MBXRD, 32'h0);
         chk("mbx order", rd, {16'h0001, ~(16'h0010 + 16'(i))});
      end
      wr(`FBM_A_MBXWR, 16'h0020);
      wr(`FBM_A_MBXWR, 16'h0021);
      repeat (20) @(posedge pclk);
      wr(`FBM_A_CTRL, 16'h0005);
      wr(`FBM_A_REFRESH, 16'h0000);
      apb(1'b0, `FBM_A_MBXRD, 32'h0);
      chk("mbx clear", rd, {16'h0001, ~16'h0021});
   endtask
   // inhibit stops the exchange, refuses commands and keeps the clear unsent
   task automatic t_inh;
      wr(`FBM_A_XMODE, 16'h0000);
      wr(`FBM_A_FAULT, 16'h0000);
      wr(`FBM_A_INIT, 16'h0000);
      wr(`FBM_A_CTRL, 16'h0001);
      @(posedge pclk);
      chk("exchange on", {31'h0, xchg}, 32'h1);
      wr(`FBM_A_CTRL, 16'h0003);
      wr(`FBM_A_MBXWR, 16'h0055);
      apb(1'b0, `FBM_A_STAT, 32'h0);
      chk("inhibit refused", {31'h0, rd[4]}, 32'h1);
      chk("exchange off", {31'h0, xchg}, 32'h0);
      wr(`FBM_A_CTRL, 16'h0002);
      repeat (3) @(posedge pclk);
      chk("inhibit clear", {30'h0, zero, send}, 32'h2);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {miscompares, checks, pulses, ticks} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_map;
      t_mbx;
      t_fault;
      t_sync;
      t_full;
      t_inh;
      close_out;
   end
endmodule
